// ---- hw/opc_counter.sv ----
// Purpose: One 16-bit reloading down counter of the pacer group.
// Assumes: countEn is high for at most one cycle per count step.
// Notes:   A reload of zero counts the full range; count zero means not yet loaded.
`timescale 1ns/1ps
module opc_counter #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             mclk,      // System clock.
  input  wire logic             sys_rst,   // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] reloadVal, // Count period in steps.
  input  wire logic             countEn,   // One count step.
  output logic      [WIDTH-1:0] cntVal,    // Current count.
  output logic                  cntOut,    // High for one count step after terminal.
  output logic                  termHit    // Terminal count is being passed this cycle.
);
  logic [WIDTH-1:0] loadVal;
  logic [WIDTH-1:0] cnt_r;
  logic             out_r;

  if (WIDTH < 2) begin : g_chk
    $error("opc_counter needs WIDTH of at least 2");
  end

  // Zero reload stands for the full range so the counter never stalls.
  assign loadVal = (reloadVal == '0) ? '1 : reloadVal;
  assign termHit = countEn && (cnt_r == WIDTH'(1));
  assign cntVal  = cnt_r;
  assign cntOut  = out_r;

  // Count down; the output rises when the terminal is passed.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r <= WIDTH'(opc_pkg::CNT_RST);
      out_r <= 1'b0;
    end else if (countEn) begin
      if (cnt_r <= WIDTH'(1)) begin
        cnt_r <= loadVal;
        out_r <= (cnt_r == WIDTH'(1));
      end else begin
        cnt_r <= cnt_r - WIDTH'(1);
        out_r <= 1'b0;
      end
    end
  end
endmodule

// ---- hw/opc_pacer_trigger.sv ----
// Purpose: Counter group, pacer and external trigger logic of an analog output card.
// Assumes: All inputs are synchronous to mclk except the four external pins.
// Notes:   External pins are synchronised here; updates start on one-cycle pulses.
`timescale 1ns/1ps

// Operation
// - Three 16-bit counters, numbered zero to two, paced by 10 MHz base.
// - Counters one and two chain into one 32-bit pacer timer.
// - Each counter two output rising edge starts one update and is driven out.
// - Counter zero counts input events or produces output pulses on its own.
// - External triggering is armed only while the enable input is high.
// - While armed, each external clock rising edge starts one update.
// - Gate input low means all external clock edges are ignored.
// - Updates on one channel may occur at up to 10 MHz.
module opc_pacer_trigger #(
  parameter int unsigned CNT_W = opc_pkg::CNT_WIDTH
) (
  input  wire logic             mclk,                  // System clock, 25 MHz.
  input  wire logic             sys_rst,               // Synchronous reset, active high.
  input  wire logic             pacerRun,              // Lets the pacer count.
  input  wire logic [CNT_W-1:0] pacerLowReload,        // Counter one period.
  input  wire logic [CNT_W-1:0] pacerHighReload,       // Counter two period.
  input  wire logic [CNT_W-1:0] c0Reload,              // Counter zero period.
  input  wire logic             c0Mode,                // Counter zero source select.
  input  wire logic             c0EventIn,             // Counter zero event input pin.
  input  wire logic             ext_trigger_enable_in, // External trigger arm level pin.
  input  wire logic             trigger_gate_level_in, // External trigger gate level pin.
  input  wire logic             ext_trigger_edge_in,   // External trigger clock pin.
  output logic      [CNT_W-1:0] c0Count,               // Counter zero count.
  output logic                  c0Out,                 // Counter zero output.
  output logic      [2*CNT_W-1:0] pacerCount,          // Chained pacer count.
  output logic                  pacerSyncOut,          // Pacer output for other equipment.
  output logic                  updateStart            // One-cycle start of an update.
);
  logic [2:0]       acc_r;
  logic [2:0]       accSum;
  logic             baseTick;
  logic [2:0]       syncIn;
  logic [2:0]       syncMid_r;
  logic [2:0]       syncOut_r;
  logic [2:0]       syncDly_r;
  logic             evRise;
  logic             extRise;
  logic             extArmed;
  logic             c0En;
  logic             c1En;
  logic             c2En;
  logic             c1Term;
  logic             c2Out;
  logic [CNT_W-1:0] c1Count;
  logic [CNT_W-1:0] c2Count;
  logic             pacerDly_r;
  logic             pacerRise;
  logic             extTrig_r;
  logic             start_r;

  if (CNT_W < 2) begin : g_chk
    $error("opc_pacer_trigger needs CNT_W of at least 2");
  end

  // The synchroniser below is built with exactly two flops per input.
  if (opc_pkg::SYNC_STAGES != 2) begin : g_sync_chk
    $error("opc_pacer_trigger supports two synchroniser stages only");
  end

  // Fractional accumulator makes an average 10 MHz tick from 25 MHz.
  assign accSum   = acc_r + opc_pkg::TICK_INC;
  assign baseTick = (accSum >= opc_pkg::TICK_MOD);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_r <= opc_pkg::ACC_RST;
    end else if (baseTick) begin
      acc_r <= accSum - opc_pkg::TICK_MOD;
    end else begin
      acc_r <= accSum;
    end
  end

  // Two-flop synchronisers for event, gate pair and trigger clock.
  assign syncIn = {c0EventIn, ext_trigger_enable_in & trigger_gate_level_in, ext_trigger_edge_in};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        syncMid_r[i] <= 1'b0;
        syncOut_r[i] <= 1'b0;
        syncDly_r[i] <= 1'b0;
      end else begin
        syncMid_r[i] <= syncIn[i];
        syncOut_r[i] <= syncMid_r[i];
        syncDly_r[i] <= syncOut_r[i];
      end
    end
  end

  // Edge detection looks only at settled stages, never the first flop.
  assign evRise   = syncOut_r[2] & ~syncDly_r[2];
  assign extArmed = syncOut_r[1];
  assign extRise  = syncOut_r[0] & ~syncDly_r[0];

  // Counter zero runs on base ticks or on input events.
  assign c0En = (c0Mode == opc_pkg::OPC_C0_PULSES) ? baseTick : evRise;
  // Counter two steps only when counter one passes its terminal.
  assign c1En = pacerRun & baseTick;
  assign c2En = c1Term;

  // The three counters share one parameterised module.
  opc_counter #(.WIDTH(CNT_W)) u_c0 (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .reloadVal (c0Reload),
    .countEn   (c0En),
    .cntVal    (c0Count),
    .cntOut    (c0Out),
    .termHit   ()
  );
  opc_counter #(.WIDTH(CNT_W)) u_c1 (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .reloadVal (pacerLowReload),
    .countEn   (c1En),
    .cntVal    (c1Count),
    .cntOut    (),
    .termHit   (c1Term)
  );
  opc_counter #(.WIDTH(CNT_W)) u_c2 (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .reloadVal (pacerHighReload),
    .countEn   (c2En),
    .cntVal    (c2Count),
    .cntOut    (c2Out),
    .termHit   ()
  );

  assign pacerCount   = {c2Count, c1Count};
  assign pacerSyncOut = c2Out;
  assign pacerRise    = c2Out & ~pacerDly_r;

  // Pacer edge history for the rising edge detector.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pacerDly_r <= 1'b0;
    end else begin
      pacerDly_r <= c2Out;
    end
  end

  // External trigger pulse, gated by the armed level.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      extTrig_r <= 1'b0;
    end else begin
      extTrig_r <= extRise & extArmed;
    end
  end

  // Update start merges both sources; each source alone is single cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      start_r <= 1'b0;
    end else begin
      start_r <= pacerRise | extTrig_r;
    end
  end
  assign updateStart = start_r;

  // Checks on pacing, chaining and triggering.
  sequence extRiseArmedSeq;
    extRise && extArmed;
  endsequence

  sequence startPulseSeq;
    start_r;
  endsequence

  tick_spacing_a: assert property (
    @(posedge mclk) disable iff (sys_rst) baseTick |=> !baseTick)
    else $error("base tick came on two adjacent cycles");

  tick_rate_a: assert property (
    @(posedge mclk) disable iff (sys_rst) baseTick |-> ##[2:3] baseTick)
    else $error("base tick gap too long for 10 MHz");

  pacer_chain_a: assert property (
    @(posedge mclk) disable iff (sys_rst) !c1Term |=> $stable(c2Count))
    else $error("counter two moved without counter one terminal");

  pacer_start_a: assert property (
    @(posedge mclk) disable iff (sys_rst) $rose(c2Out) |=> startPulseSeq)
    else $error("pacer edge did not start an update");

  event_count_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (c0Mode == opc_pkg::OPC_C0_EVENTS) && !evRise |=> $stable(c0Count))
    else $error("counter zero moved without an event");

  ext_trigger_enable_in_a: assert property (
    @(posedge mclk) disable iff (sys_rst) !extArmed |=> !extTrig_r)
    else $error("external trigger while not armed");

  ext_edge_a: assert property (
    @(posedge mclk) disable iff (sys_rst) extRiseArmedSeq |=> extTrig_r ##1 startPulseSeq)
    else $error("armed external edge did not start an update");

  gate_block_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !trigger_gate_level_in [*3] |=> !extTrig_r)
    else $error("external trigger with gate held low");

  pulse_width_a: assert property (
    @(posedge mclk) disable iff (sys_rst) extTrig_r |=> !extTrig_r)
    else $error("external trigger pulse longer than one cycle");
endmodule

// ---- pkg/opc_pkg.sv ----
// Purpose: Shared constants for the output pacer and trigger block.
// Assumes: System clock of 25 MHz; counters paced by a 10 MHz base rate.
// Notes:   The base rate is made by a fractional accumulator on the system clock.
package opc_pkg;
  localparam int unsigned MCLK_HZ     = 25_000_000; // System clock rate in hertz.
  localparam int unsigned BASE_HZ     = 10_000_000; // Counter base clock rate in hertz.
  localparam int unsigned CNT_WIDTH   = 16;         // Width of each counter.
  localparam int unsigned SYNC_STAGES = 2;          // Flops in each input synchroniser.
  // Accumulator step and modulus reduced from the two rates (25:10 is 5:2).
  localparam logic [2:0]  TICK_INC    = 3'(BASE_HZ / 5_000_000);
  localparam logic [2:0]  TICK_MOD    = 3'(MCLK_HZ / 5_000_000);
  localparam logic [15:0] CNT_RST     = 16'h0000;   // Reset count, meaning not yet loaded.
  localparam logic [2:0]  ACC_RST     = 3'h0;       // Reset value of the base-rate accumulator.

  // Counter zero source selection.
  typedef enum logic [0:0] {
    OPC_C0_EVENTS = 1'b0, // Count rising edges on the event input.
    OPC_C0_PULSES = 1'b1  // Count base ticks and emit pulses.
  } opc_c0_mode_type;
endpackage

// ---- test/opc_ext_source.sv ----
// Purpose: Outside trigger source that drives the three external trigger pins.
// Assumes: Requests from the bench change between clock edges.
// Notes:   Each fire gives one rising edge held high four cycles.
`timescale 1ns/1ps
module opc_ext_source (
  input  wire logic mclk,             // System clock.
  input  wire logic arm,              // Requested arm level.
  input  wire logic gate,             // Requested gate level.
  input  wire logic fire,             // Start one edge.
  output logic      extEnable = 1'b0, // Arm pin.
  output logic      gateLevel = 1'b0, // Gate pin.
  output logic      extEdge   = 1'b0  // External clock pin.
);
  logic [1:0] holdCnt_r = 2'h0;
  // Levels follow one edge late, as a slow real source would.
  always @(posedge mclk) begin
    extEnable <= arm;
    gateLevel <= gate;
  end
  // A long high phase lets the two-flop synchroniser see every edge.
  always @(posedge mclk) begin
    if (fire) begin
      holdCnt_r <= 2'h3;
      extEdge   <= 1'b1;
    end else if (holdCnt_r != 2'h0) begin
      holdCnt_r <= holdCnt_r - 2'h1;
    end else begin
      extEdge <= 1'b0;
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench of the pacer and trigger block.
// Assumes: Inputs change at the falling edge of a 25 MHz clock.
// Notes:   Pacer periods are measured between start pulses, in clock cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); nFail++; end end
module tb_top;
  logic        mclk = 1'b0;
  logic        sysRst = 1'b1;
  logic        pacerRun = 1'b0;
  logic [15:0] lowRel = 16'h0001;
  logic [15:0] highRel = 16'h0001;
  logic [15:0] c0Rel = 16'h0001;
  logic        c0Mode = 1'b0;
  logic        c0Event = 1'b0;
  logic        arm = 1'b0;
  logic        gate = 1'b0;
  logic        fire = 1'b0;
  logic        extEnable, gateLevel, extEdge, c0Out, pacerSyncOut, updateStart;
  logic        syncAtPulse;
  logic [15:0] c0Count;
  logic [31:0] pacerCount;
  int          cyc = 0, pulseCnt = 0, lastPulse = 0, nFail = 0, cmpCount = 0;

  opc_ext_source i_src (.mclk(mclk), .arm(arm), .gate(gate), .fire(fire),
    .extEnable(extEnable), .gateLevel(gateLevel), .extEdge(extEdge));
  opc_pacer_trigger i_dut (.mclk(mclk), .sys_rst(sysRst), .pacerRun(pacerRun),
    .pacerLowReload(lowRel), .pacerHighReload(highRel), .c0Reload(c0Rel),
    .c0Mode(c0Mode), .c0EventIn(c0Event), .ext_trigger_enable_in(extEnable),
    .trigger_gate_level_in(gateLevel), .ext_trigger_edge_in(extEdge),
    .c0Count(c0Count), .c0Out(c0Out), .pacerCount(pacerCount),
    .pacerSyncOut(pacerSyncOut), .updateStart(updateStart));

  // Clock of 40 ns period.
  initial forever #20 mclk = ~mclk;
  // Start pulses are logged with their cycle so periods need no guessing.
  always @(posedge mclk) begin
    cyc++;
    if (updateStart === 1'b1) begin
      pulseCnt++;
      lastPulse = cyc;
      syncAtPulse = pacerSyncOut;
    end
  end
  // A hung run is cut short and counted as a mismatch.
  always @(posedge mclk) if (cyc > 20000) begin
    nFail++;
    tallyAndFinish();
  end

  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic doReset();
    sysRst = 1'b1;
    repeat (5) @(negedge mclk);
    sysRst = 1'b0;
  endtask
  task automatic waitPulse(input int from);
    for (int i = 0; i < 300 && pulseCnt == from; i++) @(negedge mclk);
  endtask
  task automatic waitOut(input logic lv, output int n);
    for (n = 0; n < 100 && c0Out !== lv; n++) @(negedge mclk);
  endtask
  // Reloads 2 and 3 give six base ticks, which is fifteen clock cycles.
  task automatic testPacer();
    int first;
    lowRel = 16'h0002;
    highRel = 16'h0003;
    pacerRun = 1'b1;
    waitPulse(pulseCnt);
    first = lastPulse;
    `CHK("sync level", 1'b1, syncAtPulse)
    // Half a cycle after the counted edge the pulse must already be gone.
    `CHK("start width", 1'b0, updateStart)
    // Counter two has just reloaded and cannot step again this soon.
    `CHK("pacer high half", 16'h0003, pacerCount[31:16])
    waitPulse(pulseCnt);
    `CHK("pacer period", 15, lastPulse - first)
    pacerRun = 1'b0;
  endtask
  task automatic testExt(input logic a, input logic g, input int fires, input int ex);
    int p;
    arm = a;
    gate = g;
    repeat (8) @(negedge mclk);
    p = pulseCnt;
    for (int k = 0; k < fires; k++) begin
      fire = 1'b1;
      @(negedge mclk);
      fire = 1'b0;
      repeat (9) @(negedge mclk);
    end
    `CHK("ext starts", ex, pulseCnt - p)
  endtask
  // Pulse mode with reload 2 repeats every two ticks, five cycles.
  task automatic testC0();
    int n1;
    int n2;
    c0Mode = 1'b1;
    c0Rel = 16'h0002;
    waitOut(1'b1, n1);
    waitOut(1'b0, n1);
    waitOut(1'b1, n2);
    `CHK("c0 period", 5, n1 + n2)
    doReset();
    c0Mode = 1'b0;
    c0Rel = 16'h0003;
    for (int k = 0; k < 2; k++) begin
      c0Event = 1'b1;
      repeat (5) @(negedge mclk);
      c0Event = 1'b0;
      repeat (5) @(negedge mclk);
      `CHK("c0 events", 16'h0003 - 16'(k), c0Count)
    end
  endtask

  // Main sequence.
  initial begin
    doReset();
    `CHK("idle start", 1'b0, updateStart)
    `CHK("idle pacer", 32'h0, pacerCount)
    testPacer();
    testExt(1'b1, 1'b1, 2, 2);
    testExt(1'b1, 1'b0, 1, 0);
    testExt(1'b0, 1'b1, 1, 0);
    testC0();
    tallyAndFinish();
  end
endmodule
